// ---- imb_consts.svh ----
`ifndef IMB_CONSTS_SVH
`define IMB_CONSTS_SVH

// Register indices; byte address is four times the index
`define IMB_IDX_STATUS     6'h06
`define IMB_IDX_DATA       6'h07
`define IMB_IDX_CTRL       6'h08
`define IMB_IDX_IRQ_STAT   6'h09
`define IMB_IDX_IRQ_MASK   6'h0a
`define IMB_IDX_REQ_VIEW   6'h0b

// Status register fields
`define IMB_CODE_MSB       3
`define IMB_CODE_LSB       0
`define IMB_REQUEST_IRQ_ENABLE_BIT       4
`define IMB_VALID_BIT      5

// Interrupt status and mask fields
`define IMB_IRQ_RESP_BIT   0
`define IMB_IRQ_WDT_BIT    1

// Control register fields
`define IMB_CTRL_EN_BIT    0

// Reset values and the watchdog status code
`define IMB_CODE_RST       4'h0
`define IMB_DATA_RST       16'h0000
`define IMB_IRQ_RST        2'h0
`define IMB_CORE_RST_RST   1'b0
`define IMB_WDT_CODE       4'h0

// Bus answer latency in clocks, request to waitrequest low
`define IMB_ACK_CYCLES     1

`endif

// ---- imb_pkg.sv ----
package imb_pkg;

    typedef logic [5:0] imb_idx_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } imb_av_cmd_s;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } imb_av_rsp_s;

endpackage

// ---- imb_response_mailbox.sv ----
// Overview of operation
// - Status register carries a four-bit status code.
// - Hardware-set code blocks slave software writes; the code keeps bit four slave-writable.
// - Watchdog at maximum sets valid, code zero.
// - Watchdog status held until slave core reset.
// - Bit four enables request-valid interrupt to slave.
// - Only slave software or hardware sets valid.
// - Only master clears valid, not during lock.
// - Sixteen-bit data register resets to zero.
// - Data register read-only master, read-write slave.
// - Status register resets to all zeros.
// - Status read-only master except valid clear.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
`include "imb_consts.svh"

module imb_response_mailbox #(
    parameter int RESP_W = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  imb_pkg::imb_av_cmd_s m_av_cmd,
    output imb_pkg::imb_av_rsp_s m_av_rsp,
    input  imb_pkg::imb_av_cmd_s s_av_cmd,
    output imb_pkg::imb_av_rsp_s s_av_rsp,
    input  wire logic          wdt_at_max,
    input  wire logic          request_valid_flag,
    input  wire logic [3:0]    request_cmd_code,
    output logic               slave_core_reset,
    output logic               slave_req_irq,
    output logic               master_irq,
    output logic               status_valid_flag
);

    generate
        if (RESP_W < 1 || RESP_W > 16) begin : g_bad_width
            $error("RESP_W must lie between 1 and 16");
        end
    endgenerate

    logic [3:0]        status_code_field;
    logic              request_irq_enable;
    logic              hw_lock;
    logic [RESP_W-1:0] response_data_word;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    logic [1:0]        irq_event;
    logic [1:0]        irq_clear;
    logic [1:0]        next_irq_status;
    logic [RESP_W-1:0] data_lane_mask;
    logic [RESP_W-1:0] next_data;
    logic [31:0]       m_read_mux;
    logic [31:0]       s_read_mux;
    logic [7:0]        status_byte;
    logic              m_wr;
    logic              s_wr;
    logic              m_wr_stat;
    logic              m_wr_ctrl;
    logic              m_wr_istat;
    logic              m_wr_imask;
    logic              s_wr_stat;
    logic              s_wr_data;
    logic              s_set_valid;
    logic              wdt_hit;

    // Write commits only at the edge where waitrequest is seen low
    assign m_wr = m_av_cmd.write & ~m_av_cmd.read & ~m_av_rsp.waitrequest;
    assign s_wr = s_av_cmd.write & ~s_av_cmd.read & ~s_av_rsp.waitrequest;

    assign m_wr_stat  = m_wr && (m_av_cmd.address == {`IMB_IDX_STATUS, 2'b00}) && m_av_cmd.byteenable[0];
    assign m_wr_ctrl  = m_wr && (m_av_cmd.address == {`IMB_IDX_CTRL, 2'b00}) && m_av_cmd.byteenable[0];
    assign m_wr_istat = m_wr && (m_av_cmd.address == {`IMB_IDX_IRQ_STAT, 2'b00}) && m_av_cmd.byteenable[0];
    assign m_wr_imask = m_wr && (m_av_cmd.address == {`IMB_IDX_IRQ_MASK, 2'b00}) && m_av_cmd.byteenable[0];

    assign s_wr_stat  = s_wr && (s_av_cmd.address == {`IMB_IDX_STATUS, 2'b00}) && s_av_cmd.byteenable[0];
    assign s_wr_data  = s_wr && (s_av_cmd.address == {`IMB_IDX_DATA, 2'b00});

    assign s_set_valid = s_wr_stat & s_av_cmd.writedata[`IMB_VALID_BIT];

    // Watchdog ignored while slave core is held in reset
    assign wdt_hit = wdt_at_max & ~slave_core_reset;

    assign status_byte = {2'b00, status_valid_flag, request_irq_enable, status_code_field};

    // Byte lanes of the data word
    genvar gi;
    generate
        for (gi = 0; gi < RESP_W; gi++) begin : g_lane
            assign data_lane_mask[gi] = s_av_cmd.byteenable[gi / 8];
        end
    endgenerate

    assign next_data = (response_data_word & ~data_lane_mask)
                     | (s_av_cmd.writedata[RESP_W-1:0] & data_lane_mask);

    // Master port read map
    always_comb begin
        m_read_mux = 32'h0000_0000;
        unique case (m_av_cmd.address)
            {`IMB_IDX_STATUS, 2'b00}: begin
                m_read_mux = {24'h00_0000, status_byte};
            end
            {`IMB_IDX_DATA, 2'b00}: begin
                m_read_mux = {{(32-RESP_W){1'b0}}, response_data_word};
            end
            {`IMB_IDX_CTRL, 2'b00}: begin
                m_read_mux = {31'h0000_0000, ~slave_core_reset};
            end
            {`IMB_IDX_IRQ_STAT, 2'b00}: begin
                m_read_mux = {30'h0000_0000, irq_status};
            end
            {`IMB_IDX_IRQ_MASK, 2'b00}: begin
                m_read_mux = {30'h0000_0000, irq_mask};
            end
            default: begin
                m_read_mux = 32'h0000_0000;
            end
        endcase
    end

    // Slave port read map
    always_comb begin
        s_read_mux = 32'h0000_0000;
        unique case (s_av_cmd.address)
            {`IMB_IDX_STATUS, 2'b00}: begin
                s_read_mux = {24'h00_0000, status_byte};
            end
            {`IMB_IDX_DATA, 2'b00}: begin
                s_read_mux = {{(32-RESP_W){1'b0}}, response_data_word};
            end
            {`IMB_IDX_REQ_VIEW, 2'b00}: begin
                s_read_mux = {26'h000_0000, request_valid_flag, 1'b0, request_cmd_code};
            end
            default: begin
                s_read_mux = 32'h0000_0000;
            end
        endcase
    end

    // Master port handshake, one wait cycle per access
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            m_av_rsp.waitrequest <= 1'b1;
            m_av_rsp.readdata    <= 32'h0000_0000;
        end else if ((m_av_cmd.read ^ m_av_cmd.write) && m_av_rsp.waitrequest) begin
            m_av_rsp.waitrequest <= 1'b0;
            m_av_rsp.readdata    <= m_av_cmd.read ? m_read_mux : 32'h0000_0000;
        end else begin
            m_av_rsp.waitrequest <= 1'b1;
            m_av_rsp.readdata    <= m_av_rsp.readdata;
        end
    end

    // Slave port handshake, same timing as master port
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_av_rsp.waitrequest <= 1'b1;
            s_av_rsp.readdata    <= 32'h0000_0000;
        end else if ((s_av_cmd.read ^ s_av_cmd.write) && s_av_rsp.waitrequest) begin
            s_av_rsp.waitrequest <= 1'b0;
            s_av_rsp.readdata    <= s_av_cmd.read ? s_read_mux : 32'h0000_0000;
        end else begin
            s_av_rsp.waitrequest <= 1'b1;
            s_av_rsp.readdata    <= s_av_rsp.readdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slave_core_reset <= `IMB_CORE_RST_RST;
        end else if (m_wr_ctrl) begin
            slave_core_reset <= ~m_av_cmd.writedata[`IMB_CTRL_EN_BIT];
        end
    end

    // Lock marks a hardware-owned status
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hw_lock <= 1'b0;
        end else if (slave_core_reset) begin
            hw_lock <= 1'b0;
        end else if (wdt_hit) begin
            hw_lock <= 1'b1;
        end
    end

    // Status code field
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_code_field <= `IMB_CODE_RST;
        end else if (slave_core_reset) begin
            status_code_field <= `IMB_CODE_RST;
        end else if (wdt_hit) begin
            status_code_field <= `IMB_WDT_CODE;
        end else if (s_wr_stat && !hw_lock) begin
            status_code_field <= s_av_cmd.writedata[`IMB_CODE_MSB:`IMB_CODE_LSB];
        end
    end

    // Request interrupt enable stays writable under lock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            request_irq_enable <= 1'b0;
        end else if (slave_core_reset) begin
            request_irq_enable <= 1'b0;
        end else if (s_wr_stat) begin
            request_irq_enable <= s_av_cmd.writedata[`IMB_REQUEST_IRQ_ENABLE_BIT];
        end
    end

    // Status valid flag; any set beats a master clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_valid_flag <= 1'b0;
        end else if (slave_core_reset) begin
            status_valid_flag <= 1'b0;
        end else if (wdt_hit) begin
            status_valid_flag <= 1'b1;
        end else if (s_set_valid) begin
            status_valid_flag <= 1'b1;
        end else if (m_wr_stat && !m_av_cmd.writedata[`IMB_VALID_BIT] && !hw_lock) begin
            status_valid_flag <= 1'b0;
        end
    end

    // Response data word; no guard against overwrite, software keeps the order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            response_data_word <= RESP_W'(`IMB_DATA_RST);
        end else if (slave_core_reset) begin
            response_data_word <= RESP_W'(`IMB_DATA_RST);
        end else if (s_wr_data) begin
            // relies on slave waiting for clear
            response_data_word <= next_data;
        end
    end

    // Events for the master interrupt
    always_comb begin
        irq_event                    = 2'b00;
        irq_event[`IMB_IRQ_RESP_BIT] = s_set_valid & ~status_valid_flag & ~slave_core_reset;
        irq_event[`IMB_IRQ_WDT_BIT]  = wdt_hit & ~hw_lock;
        irq_clear                    = m_wr_istat ? m_av_cmd.writedata[1:0] : 2'b00;
        // Set wins over a simultaneous clear
        next_irq_status              = (irq_status & ~irq_clear) | irq_event;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_status <= `IMB_IRQ_RST;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_mask <= `IMB_IRQ_RST;
        end else if (m_wr_imask) begin
            irq_mask <= m_av_cmd.writedata[1:0];
        end
    end

    // One clock behind the status bits to keep the output a flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            master_irq <= 1'b0;
        end else begin
            master_irq <= |(irq_status & irq_mask);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slave_req_irq <= 1'b0;
        end else begin
            slave_req_irq <= request_irq_enable & request_valid_flag;
        end
    end

endmodule // imb_response_mailbox

// ---- imb_core_model.sv ----
`timescale 1ns/1ns
module imb_core_model (
    input  wire logic            clk_sys,
    output imb_pkg::imb_av_cmd_s av_cmd,
    input  imb_pkg::imb_av_rsp_s av_rsp
);
    // Byte lanes; the bench may narrow them for one access
    logic [3:0] lane_en = 4'hf;
    initial av_cmd = '0;
    // Request held until waitrequest low, for at most 16 clocks
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
        ok = 1'b0;
        q = '0;
        @(posedge clk_sys);
        av_cmd <= '{read: !w, write: w, address: a, byteenable: lane_en, writedata: d};
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk_sys);
            if (av_rsp.waitrequest === 1'b0) begin
                ok = 1'b1;
                q = av_rsp.readdata;
            end
        end
        // Released address and data lines never keep the old value
        av_cmd <= '{read: 1'b0, write: 1'b0, address: ~a, byteenable: 4'h0, writedata: ~d};
    endtask
endmodule // imb_core_model

// ---- imb_response_mailbox_checker.sv ----
`timescale 1ns/1ns
module imb_response_mailbox_checker #(
    parameter int RESP_W = 16
) (
    input wire logic           clk_sys,
    input wire logic           rst,
    input imb_pkg::imb_av_cmd_s m_av_cmd,
    input imb_pkg::imb_av_rsp_s m_av_rsp,
    input imb_pkg::imb_av_cmd_s s_av_cmd,
    input imb_pkg::imb_av_rsp_s s_av_rsp,
    input wire logic           wdt_at_max,
    input wire logic           request_valid_flag,
    input wire logic [3:0]     request_cmd_code,
    input wire logic           slave_core_reset,
    input wire logic           slave_req_irq,
    input wire logic           master_irq,
    input wire logic           status_valid_flag
);
    logic m_go;
    logic s_st;
    logic lock_seen;
    assign m_go = m_av_cmd.write && !m_av_rsp.waitrequest && m_av_cmd.byteenable[0];
    assign s_st = s_av_cmd.write && !s_av_rsp.waitrequest && s_av_cmd.address == 8'h18;
    // Mirror of the watchdog lock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            lock_seen <= 1'b0;
        else if (slave_core_reset)
            lock_seen <= 1'b0;
        else if (wdt_at_max)
            lock_seen <= 1'b1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_ctrl_off;
        m_go && m_av_cmd.address == 8'h20 && !m_av_cmd.writedata[0];
    endsequence
    sequence s_core_down;
        ##[1:3] slave_core_reset;
    endsequence
    property p_core_reset;
        s_ctrl_off |-> s_core_down;
    endproperty
    a_core_reset: assert property (p_core_reset) else $error("core reset late");
    property p_wdt_set;
        wdt_at_max && !slave_core_reset |=> status_valid_flag;
    endproperty
    a_wdt_set: assert property (p_wdt_set) else $error("wdt valid missing");
    property p_wdt_hold;
        lock_seen && !slave_core_reset |-> status_valid_flag;
    endproperty
    a_wdt_hold: assert property (p_wdt_hold) else $error("wdt valid lost");
    property p_valid_rise;
        $rose(status_valid_flag) |-> $past(s_st && s_av_cmd.writedata[5]) || $past(wdt_at_max);
    endproperty
    a_valid_rise: assert property (p_valid_rise) else $error("valid set by master");
    property p_valid_keep;
        status_valid_flag && !(m_go && m_av_cmd.address == 8'h18) && !slave_core_reset |=> status_valid_flag;
    endproperty
    a_valid_keep: assert property (p_valid_keep) else $error("valid lost");
    property p_clear;
        m_go && m_av_cmd.address == 8'h18 && !m_av_cmd.writedata[5] && !lock_seen && !s_st && !wdt_at_max
            |=> !status_valid_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("valid not cleared");
    property p_core_clear;
        slave_core_reset |=> !status_valid_flag;
    endproperty
    a_core_clear: assert property (p_core_clear) else $error("valid kept in reset");
    property p_req_irq;
        !request_valid_flag |=> !slave_req_irq;
    endproperty
    a_req_irq: assert property (p_req_irq) else $error("request irq without flag");
endmodule // imb_response_mailbox_checker

// ---- imb_response_mailbox_tb.sv ----
`timescale 1ns/1ns
module imb_response_mailbox_tb;
    typedef struct packed {
        logic        ws;
        logic        rs;
        logic [7:0]  a;
        logic [31:0] wd;
        logic [31:0] exp;
    } imb_row_s;
    localparam logic M = 1'b0;
    localparam logic S = 1'b1;
    localparam logic R = 1'b0;
    localparam logic W = 1'b1;
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    logic                 wdt_at_max = 1'b0;
    logic                 request_valid_flag = 1'b1;
    logic [3:0]           request_cmd_code = 4'h9;
    imb_pkg::imb_av_cmd_s m_av_cmd;
    imb_pkg::imb_av_cmd_s s_av_cmd;
    imb_pkg::imb_av_rsp_s m_av_rsp;
    imb_pkg::imb_av_rsp_s s_av_rsp;
    logic                 slave_core_reset;
    logic                 slave_req_irq;
    logic                 master_irq;
    logic                 status_valid_flag;
    logic [31:0]          q;
    int                   fail_count = 0;
    int                   samples_checked = 0;
    // data before valid, rewrite after clear
    imb_row_s rows [11] = '{
        '{S, M, 8'h1c, 32'h1234, 32'h1234}, '{M, M, 8'h1c, 32'hffff, 32'h1234},
        '{S, M, 8'h18, 32'h001a, 32'h001a}, '{M, M, 8'h18, 32'h0005, 32'h001a},
        '{S, M, 8'h18, 32'h003a, 32'h003a}, '{S, S, 8'h18, 32'h001a, 32'h003a},
        '{M, M, 8'h18, 32'h0000, 32'h001a}, '{S, M, 8'h1c, 32'h5678, 32'h5678}, '{M, M, 8'h3c, 32'h00ff, 32'h0000},
        '{M, M, 8'h28, 32'h0000, 32'h0000}, '{S, S, 8'h2c, 32'h0000, 32'h0029}};
    always #20 clk_sys = ~clk_sys;
    imb_core_model imb_core_model_inst (.clk_sys(clk_sys), .av_cmd(m_av_cmd), .av_rsp(m_av_rsp));
    imb_core_model imb_core_model_inst_s (.clk_sys(clk_sys), .av_cmd(s_av_cmd), .av_rsp(s_av_rsp));
    imb_response_mailbox #(.RESP_W(16)) imb_response_mailbox_inst (
        .clk_sys(clk_sys), .rst(rst), .m_av_cmd(m_av_cmd), .m_av_rsp(m_av_rsp), .s_av_cmd(s_av_cmd),
        .s_av_rsp(s_av_rsp), .wdt_at_max(wdt_at_max), .request_valid_flag(request_valid_flag),
        .request_cmd_code(request_cmd_code), .slave_core_reset(slave_core_reset),
        .slave_req_irq(slave_req_irq), .master_irq(master_irq), .status_valid_flag(status_valid_flag));
    task automatic complete_run();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bounded bus wait; a hang ends the run
    task automatic acc(input logic slv, input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        bit ok;
        if (slv)
            imb_core_model_inst_s.xfer(w, a, d, rd, ok);
        else
            imb_core_model_inst.xfer(w, a, d, rd, ok);
        if (!ok) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge clk_sys);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        acc(M, R, 8'h18, 32'h0, q);
        chk("status reset", q, 32'h0);
        acc(M, R, 8'h1c, 32'h0, q);
        chk("data reset", q, 32'h0);
        acc(M, R, 8'h20, 32'h0, q);
        chk("ctrl reset", q, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 11; i++) begin
            acc(rows[i].ws, W, rows[i].a, rows[i].wd, q);
            acc(rows[i].rs, R, rows[i].a, 32'h0, q);
            chk("table read", q, rows[i].exp);
        end
        // Low byte lane only, data rewritten after master clear
        imb_core_model_inst_s.lane_en = 4'h1;
        acc(S, W, 8'h1c, 32'habcd, q);
        imb_core_model_inst_s.lane_en = 4'hf;
        acc(M, R, 8'h1c, 32'h0, q);
        chk("data lane", q, 32'h56cd);
        $display("test table done");
        acc(M, R, 8'h24, 32'h0, q);
        chk("irq status", q, 32'h1);
        acc(M, W, 8'h28, 32'h3, q);
        settle();
        chk("irq on", {31'h0, master_irq}, 32'h1);
        acc(M, W, 8'h24, 32'h1, q);
        settle();
        chk("irq off", {31'h0, master_irq}, 32'h0);
        chk("req irq", {31'h0, slave_req_irq}, 32'h1);
        @(posedge clk_sys) request_valid_flag <= 1'b0;
        settle();
        chk("req irq gone", {31'h0, slave_req_irq}, 32'h0);
        @(posedge clk_sys) request_valid_flag <= 1'b1;
        $display("test irq done");
        @(posedge clk_sys) wdt_at_max <= 1'b1;
        @(posedge clk_sys) wdt_at_max <= 1'b0;
        acc(S, W, 8'h18, 32'h2f, q);
        acc(M, W, 8'h18, 32'h0, q);
        acc(M, R, 8'h18, 32'h0, q);
        chk("wdt status", q, 32'h20);
        chk("req irq masked", {31'h0, slave_req_irq}, 32'h0);
        acc(M, R, 8'h24, 32'h0, q);
        chk("wdt irq", q, 32'h2);
        acc(M, W, 8'h20, 32'h0, q);
        settle();
        chk("core reset", {31'h0, slave_core_reset}, 32'h1);
        acc(M, R, 8'h18, 32'h0, q);
        chk("status cleared", q, 32'h0);
        acc(M, R, 8'h1c, 32'h0, q);
        chk("data cleared", q, 32'h0);
        acc(M, W, 8'h20, 32'h1, q);
        acc(S, W, 8'h18, 32'h07, q);
        acc(M, R, 8'h18, 32'h0, q);
        chk("lock released", q, 32'h7);
        $display("test watchdog done");
        complete_run();
    end
endmodule // imb_response_mailbox_tb
bind imb_response_mailbox imb_response_mailbox_checker #(.RESP_W(RESP_W)) imb_response_mailbox_checker_inst (
    .clk_sys(clk_sys), .rst(rst), .m_av_cmd(m_av_cmd), .m_av_rsp(m_av_rsp), .s_av_cmd(s_av_cmd),
    .s_av_rsp(s_av_rsp), .wdt_at_max(wdt_at_max), .request_valid_flag(request_valid_flag),
    .request_cmd_code(request_cmd_code), .slave_core_reset(slave_core_reset),
    .slave_req_irq(slave_req_irq), .master_irq(master_irq), .status_valid_flag(status_valid_flag));
